//--- include/ptpc_pkg.sv
// Package for the precision clock, rate trim and interrupt block.
`default_nettype none

package ptpc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int GPIO_MIN_NS   = 40;
  localparam int GPIO_MIN_CYC  =
    (GPIO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0]  GPIO_HOLD_CNT  = 3'(GPIO_MIN_CYC);
  localparam logic [3:0]  INC_NOMINAL_NS = 4'(CLK_PERIOD_NS);
  localparam logic [3:0]  INC_SLOW_NS    = 4'h9;
  localparam logic [3:0]  INC_FAST_NS    = 4'hb;
  localparam logic [30:0] NS_PER_SEC     = 31'h3b9aca00;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CMD       = 12'h100;
  localparam logic [11:0] ADDR_INT_STAT  = 12'h108;
  localparam logic [11:0] ADDR_INT_EN    = 12'h10c;
  localparam logic [11:0] ADDR_CLK_SEC   = 12'h110;
  localparam logic [11:0] ADDR_CLK_NS    = 12'h114;
  localparam logic [11:0] ADDR_CLK_FRAC  = 12'h118;
  localparam logic [11:0] ADDR_TRIM      = 12'h11c;
  localparam logic [11:0] ADDR_TGT_A_SEC = 12'h12c;
  localparam logic [11:0] ADDR_TGT_A_NS  = 12'h130;
  localparam logic [11:0] ADDR_TGT_B_SEC = 12'h13c;
  localparam logic [11:0] ADDR_TGT_B_NS  = 12'h140;
  localparam logic [11:0] ADDR_TOP_STAT  = 12'h150;
  localparam logic [11:0] ADDR_TOP_EN    = 12'h154;
  localparam logic [11:0] ADDR_GPIO_CLR  = 12'h158;

  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int CMD_READ_BIT  = 0;
  localparam int CMD_LOAD_BIT  = 1;
  localparam int TRIM_DIR_BIT  = 31;
  localparam int CLR_RISE_BIT  = 8;
  localparam logic [31:0] STAT_MASK = 32'hffff7703;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } ptpc_bus_req_t;

  typedef struct packed {
    logic [7:0] fallCap;
    logic [7:0] riseCap;
    logic [2:0] egress;
    logic [2:0] ingress;
  } ptpc_events_t;

  typedef struct packed {
    logic [31:0] sec;
    logic [29:0] ns;
    logic [31:0] frac;
    logic [31:0] ldSec;
    logic [29:0] ldNs;
    logic [31:0] ldFrac;
    logic [31:0] snSec;
    logic [29:0] snNs;
    logic [31:0] snFrac;
    logic        trimDir;
    logic [29:0] trimAmt;
    logic [31:0] intEn;
    logic [31:0] intStat;
    logic [31:0] tgtASec;
    logic [29:0] tgtANs;
    logic [31:0] tgtBSec;
    logic [29:0] tgtBNs;
    logic [1:0]  matchPrev;
    logic        topEn;
    logic [7:0]  clrEn;
    logic        clrRise;
    logic [31:0] rdata;
  } ptpc_state_t;

  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       level;
    logic [2:0] cnt;
    logic       pulse;
  } ptpc_filt_t;

  localparam ptpc_state_t STATE_RST = '0;
  localparam ptpc_filt_t  FILT_RST  = '0;

endpackage

`default_nettype wire

//--- src/ptpc_clock_unit.sv
// Precision clock with rate trim, timer match and interrupt gating.
// Behaviour
// - Set timer B flag when clock reaches target.
// - Set timer A flag when clock reaches target.
// - Status bits clear on written one, not on written zero.
// - Filtered active pin edge clears timer flags.
// - Enabled status bits OR into summary event.
// - Status bits update regardless of enables.
// - Interrupt output also needs summary event enable.
// - Capture edge enables in bits 31:16.
// - Stamp enables in bits 14:12, 10:8.
// - Timer enables bits 1:0; reserved read zero.
// - Clock reads return snapshot from read command.
// - Load command copies written values into clock.
// - Seconds 32, nanoseconds 30, fraction 32 bits.
// - Clock advances 10 ns each cycle without fraction wrap.
// - Trim amount adds to fraction each cycle.
// - Fraction wrap alters increment by 1 ns.
// - Direction bit picks 9 or 11 ns.
`timescale 1ns/10ps
`default_nettype none

module ptpc_clock_unit
  import ptpc_pkg::*;
(
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst_b,
  // Register port
  input  wire ptpc_bus_req_t busReq,
  output logic [31:0]        busRdata,
  // Event sources
  input  wire ptpc_events_t  stampEvents,
  input  wire logic [7:0]    gpioPin,
  // Interrupt
  output logic               irqOut
);

  ptpc_state_t state_reg;
  ptpc_state_t state_next;

  logic [32:0] fracSum;
  logic [3:0]  tickInc;
  logic [30:0] nsSum;
  logic [30:0] nsFold;
  logic        nsWrap;
  logic [1:0]  matchNow;
  logic [1:0]  matchRise;
  logic [7:0]  gpioEdge;
  logic        gpioClr;
  logic [31:0] statSet;
  logic [31:0] statClr;
  logic [31:0] rdVal;
  logic        cmdWr;
  logic        cmdLoad;
  logic        cmdRead;
  logic        summary;

  // ----------------------------------------------------------------
  // Pin edge filters
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : gFilt
    ptpc_edge_filter uFilt (
      .clock      (clock),
      .rst_b      (rst_b),
      .pinIn      (gpioPin[i]),
      .activeHigh (state_reg.clrRise),
      .edgePulse  (gpioEdge[i])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cmdWr   = busReq.wr && (busReq.addr == ADDR_CMD);
    cmdLoad = cmdWr && busReq.wdata[CMD_LOAD_BIT];
    cmdRead = cmdWr && busReq.wdata[CMD_READ_BIT];

    // Rate trim and tick.
    fracSum = {1'b0, state_reg.frac} + {3'h0, state_reg.trimAmt};
    if (fracSum[32]) begin
      tickInc = state_reg.trimDir ? INC_FAST_NS : INC_SLOW_NS;
    end else begin
      tickInc = INC_NOMINAL_NS;
    end
    nsSum  = {1'b0, state_reg.ns} + {27'h0, tickInc};
    nsFold = nsSum - NS_PER_SEC;
    nsWrap = (nsSum >= NS_PER_SEC);
    state_next.frac = fracSum[31:0];
    if (nsWrap) begin
      state_next.ns  = nsFold[29:0];
      state_next.sec = state_reg.sec + 32'h1;
    end else begin
      state_next.ns = nsSum[29:0];
    end

    // Timer match, flagged when the compare first holds.
    matchNow[0] = {state_reg.sec, state_reg.ns} >=
                  {state_reg.tgtASec, state_reg.tgtANs};
    matchNow[1] = {state_reg.sec, state_reg.ns} >=
                  {state_reg.tgtBSec, state_reg.tgtBNs};
    matchRise = matchNow & ~state_reg.matchPrev;
    state_next.matchPrev = matchNow;

    // Sticky status; a new event wins over a clear.
    gpioClr = |(gpioEdge & state_reg.clrEn);
    statSet = {stampEvents.fallCap, stampEvents.riseCap, 1'b0,
               stampEvents.egress, 1'b0, stampEvents.ingress,
               6'h00, matchRise};
    statClr = 32'h0;
    if (busReq.wr && (busReq.addr == ADDR_INT_STAT)) begin
      statClr = busReq.wdata;
    end
    if (gpioClr) begin
      statClr = statClr | 32'h3;
    end
    state_next.intStat =
      ((state_reg.intStat & ~statClr) | statSet) & STAT_MASK;

    // Register writes.
    if (busReq.wr) begin
      unique case (busReq.addr)
        ADDR_INT_EN: begin
          state_next.intEn = busReq.wdata & STAT_MASK;
        end
        ADDR_CLK_SEC: begin
          state_next.ldSec = busReq.wdata;
        end
        ADDR_CLK_NS: begin
          state_next.ldNs = busReq.wdata[29:0];
        end
        ADDR_CLK_FRAC: begin
          state_next.ldFrac = busReq.wdata;
        end
        ADDR_TRIM: begin
          state_next.trimDir = busReq.wdata[TRIM_DIR_BIT];
          state_next.trimAmt = busReq.wdata[29:0];
        end
        ADDR_TGT_A_SEC: begin
          state_next.tgtASec = busReq.wdata;
        end
        ADDR_TGT_A_NS: begin
          state_next.tgtANs = busReq.wdata[29:0];
        end
        ADDR_TGT_B_SEC: begin
          state_next.tgtBSec = busReq.wdata;
        end
        ADDR_TGT_B_NS: begin
          state_next.tgtBNs = busReq.wdata[29:0];
        end
        ADDR_TOP_EN: begin
          state_next.topEn = busReq.wdata[0];
        end
        ADDR_GPIO_CLR: begin
          state_next.clrEn   = busReq.wdata[7:0];
          state_next.clrRise = busReq.wdata[CLR_RISE_BIT];
        end
        default: begin
        end
      endcase
    end

    // Clock commands.
    if (cmdRead) begin
      state_next.snSec  = state_reg.sec;
      state_next.snNs   = state_reg.ns;
      state_next.snFrac = state_reg.frac;
    end
    if (cmdLoad) begin
      state_next.sec  = state_reg.ldSec;
      state_next.ns   = state_reg.ldNs;
      state_next.frac = state_reg.ldFrac;
    end

    // Register reads, answered in the next cycle.
    summary = |(state_reg.intStat & state_reg.intEn);
    unique case (busReq.addr)
      ADDR_INT_STAT: rdVal = state_reg.intStat;
      ADDR_INT_EN:   rdVal = state_reg.intEn;
      ADDR_CLK_SEC:  rdVal = state_reg.snSec;
      ADDR_CLK_NS:   rdVal = {2'b00, state_reg.snNs};
      ADDR_CLK_FRAC: rdVal = state_reg.snFrac;
      ADDR_TRIM: begin
        rdVal = {state_reg.trimDir, 1'b0, state_reg.trimAmt};
      end
      ADDR_TGT_A_SEC: rdVal = state_reg.tgtASec;
      ADDR_TGT_A_NS:  rdVal = {2'b00, state_reg.tgtANs};
      ADDR_TGT_B_SEC: rdVal = state_reg.tgtBSec;
      ADDR_TGT_B_NS:  rdVal = {2'b00, state_reg.tgtBNs};
      ADDR_TOP_STAT:  rdVal = {31'h0, summary};
      ADDR_TOP_EN:    rdVal = {31'h0, state_reg.topEn};
      ADDR_GPIO_CLR: begin
        rdVal = {23'h0, state_reg.clrRise, state_reg.clrEn};
      end
      default: rdVal = 32'h0;
    endcase
    state_next.rdata = busReq.rd ? rdVal : 32'h0;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign busRdata = state_reg.rdata;
  assign irqOut   = summary && state_reg.topEn;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  matchASet_a: assert property (
    matchRise[0] |=> state_reg.intStat[0]
  ) else $error("timer A match did not set its flag");

  matchBSet_a: assert property (
    $rose(matchNow[1]) |=> state_reg.intStat[1]
  ) else $error("timer B match did not set its flag");

  noEnableNeed_a: assert property (
    matchRise[1] && !state_reg.intEn[1] |=> state_reg.intStat[1]
  ) else $error("status bit gated by its enable");

  statW1c_a: assert property (
    busReq.wr && busReq.addr == ADDR_INT_STAT && busReq.wdata[0]
    && !matchRise[0] |=> !state_reg.intStat[0]
  ) else $error("write one did not clear status");

  statHold_a: assert property (
    busReq.wr && busReq.addr == ADDR_INT_STAT && !busReq.wdata[0]
    && state_reg.intStat[0] && !gpioClr |=> state_reg.intStat[0]
  ) else $error("write zero changed status");

  gpioClear_a: assert property (
    gpioClr && matchRise == 2'b00 |=> state_reg.intStat[1:0] == 2'b00
  ) else $error("pin edge did not clear timer flags");

  gpioFilter_a: assert property (
    $rose(gpioEdge[0]) |-> $past(gFilt[0].uFilt.state_reg.sync2, 5)
    == gFilt[0].uFilt.state_reg.level
  ) else $error("pin edge accepted too early");

  irqGate_a: assert property (
    state_reg.topEn && (state_reg.intStat[0] && state_reg.intEn[0])
    |-> irqOut
  ) else $error("enabled status not raising interrupt");

  irqMask_a: assert property (
    !state_reg.topEn |-> !irqOut
  ) else $error("interrupt without summary enable");

  enResv_a: assert property (
    busReq.wr && busReq.addr == ADDR_INT_EN |=>
    state_reg.intEn == ($past(busReq.wdata) & STAT_MASK)
  ) else $error("enable register layout wrong");

  nsResv_a: assert property (
    busReq.rd && busReq.addr == ADDR_CLK_NS |=> busRdata[31:30] == 2'b00
  ) else $error("reserved nanosecond bits set");

  snapRead_a: assert property (
    cmdRead ##1 busReq.rd && busReq.addr == ADDR_CLK_SEC
    && !cmdRead |=> busRdata == $past(state_reg.sec, 2)
  ) else $error("seconds read is not the snapshot");

  loadClk_a: assert property (
    cmdLoad |=> state_reg.sec == $past(state_reg.ldSec)
    && state_reg.ns == $past(state_reg.ldNs)
    && state_reg.frac == $past(state_reg.ldFrac)
  ) else $error("load did not replace clock");

  tickNom_a: assert property (
    !cmdLoad && !fracSum[32] && !nsWrap |=>
    state_reg.ns == $past(state_reg.ns) + 30'h00a
  ) else $error("nominal tick is not 10 ns");

  fracAcc_a: assert property (
    !cmdLoad |=> state_reg.frac ==
    $past(state_reg.frac) + {2'b00, $past(state_reg.trimAmt)}
  ) else $error("fraction did not accumulate trim");

  tickTrim_a: assert property (
    !cmdLoad && fracSum[32] && !nsWrap |=> state_reg.ns ==
    $past(state_reg.ns) + ($past(state_reg.trimDir) ? 30'h00b : 30'h009)
  ) else $error("wrap tick is not 9 or 11 ns");

  secCarry_a: assert property (
    !cmdLoad && nsWrap |=> state_reg.sec == $past(state_reg.sec) + 32'h1
    && state_reg.ns < 30'h3b9aca00
  ) else $error("nanosecond fold into seconds wrong");

endmodule

`default_nettype wire

//--- src/ptpc_edge_filter.sv
// Synchroniser and glitch filter that flags an active pin edge.
`timescale 1ns/10ps
`default_nettype none

module ptpc_edge_filter
  import ptpc_pkg::*;
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // Pin and polarity
  input  wire logic pinIn,
  input  wire logic activeHigh,
  // Edge event
  output logic      edgePulse
);

  ptpc_filt_t state_reg;
  ptpc_filt_t state_next;

  // ----------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.sync1 = pinIn;
    state_next.sync2 = state_reg.sync1;
    state_next.pulse = 1'b0;
    if (state_reg.sync2 != state_reg.level) begin
      if (state_reg.cnt == GPIO_HOLD_CNT) begin
        state_next.level = state_reg.sync2;
        state_next.cnt   = 3'h0;
        state_next.pulse = (state_reg.sync2 == activeHigh);
      end else begin
        state_next.cnt = state_reg.cnt + 3'h1;
      end
    end else begin
      state_next.cnt = 3'h0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= FILT_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign edgePulse = state_reg.pulse;

endmodule

`default_nettype wire

//--- verification/test_ptp_clock_irq_and_rate_adjust.sv
// Self-checking bench for the precision clock and interrupt block.
`timescale 1ns/10ps
`default_nettype none

module test_ptp_clock_irq_and_rate_adjust
  import ptpc_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic          clock = 1'b0;
  logic          rst_b;
  ptpc_bus_req_t busReq;
  logic [31:0]   busRdata;
  ptpc_events_t  stampEvents;
  logic [7:0]    gpioPin;
  logic          irqOut;
  int            failCount;
  int            testsRun;

  ptpc_clock_unit DUT (
    .clock       (clock),
    .rst_b       (rst_b),
    .busReq      (busReq),
    .busRdata    (busRdata),
    .stampEvents (stampEvents),
    .gpioPin     (gpioPin),
    .irqOut      (irqOut)
  );

  always #5 clock = ~clock;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("Checks made %0d, mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      failCount++;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    busReq.wr <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [11:0] a,
                      input logic [31:0] exp);
    @(posedge clock);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clock);
    busReq.rd <= 1'b0;
    #1;
    chk(what, exp, busRdata);
  endtask

  task automatic irqchk(input logic e);
    #1;
    chk("irqOut", {31'h0, e}, {31'h0, irqOut});
  endtask

  task automatic clk_set(input logic [31:0] s, input logic [31:0] n,
                         input logic [31:0] f);
    wr(ADDR_CLK_SEC, s);
    wr(ADDR_CLK_NS, n);
    wr(ADDR_CLK_FRAC, f);
    wr(ADDR_CMD, 32'h2);
    wr(ADDR_CMD, 32'h1);
  endtask

  task automatic pin(input int n, input int len);
    @(posedge clock);
    gpioPin[n] <= 1'b1;
    repeat (len) @(posedge clock);
    gpioPin[n] <= 1'b0;
    repeat (12) @(posedge clock);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk("enables", ADDR_INT_EN, 32'h0);
    rchk("seconds", ADDR_CLK_SEC, 32'h0);
    rchk("nanoseconds", ADDR_CLK_NS, 32'h0);
    rchk("fraction", ADDR_CLK_FRAC, 32'h0);
    rchk("trim", ADDR_TRIM, 32'h0);
    rchk("unmapped", 12'h1fc, 32'h0);
    wr(ADDR_INT_EN, 32'hffffffff);
    rchk("enable mask", ADDR_INT_EN, 32'hffff7703);
    wr(ADDR_INT_EN, 32'h0);
    $display("test reset_values done");
  endtask

  task automatic t_irq();
    rchk("status", ADDR_INT_STAT, 32'h3);
    irqchk(1'b0);
    wr(ADDR_INT_STAT, 32'h1);
    rchk("w1c one", ADDR_INT_STAT, 32'h2);
    wr(ADDR_INT_STAT, 32'h0);
    rchk("w1c zero", ADDR_INT_STAT, 32'h2);
    wr(ADDR_INT_EN, 32'h2);
    rchk("summary", ADDR_TOP_STAT, 32'h1);
    irqchk(1'b0);
    wr(ADDR_TOP_EN, 32'h1);
    irqchk(1'b1);
    wr(ADDR_INT_STAT, 32'h2);
    irqchk(1'b0);
    @(posedge clock);
    stampEvents <= '1;
    @(posedge clock);
    stampEvents <= '0;
    rchk("events", ADDR_INT_STAT, 32'hffff7700);
    irqchk(1'b0);
    wr(ADDR_INT_EN, 32'h400);
    irqchk(1'b1);
    wr(ADDR_INT_STAT, 32'hffffffff);
    irqchk(1'b0);
    rchk("cleared", ADDR_INT_STAT, 32'h0);
    wr(ADDR_INT_EN, 32'h0);
    wr(ADDR_TOP_EN, 32'h0);
    $display("test interrupt_gating done");
  endtask

  task automatic t_match();
    wr(ADDR_TGT_A_SEC, 32'h1);
    wr(ADDR_TGT_B_SEC, 32'h1);
    clk_set(32'h0, 32'h0, 32'h0);
    wr(ADDR_TGT_A_NS, 32'h190);
    wr(ADDR_TGT_A_SEC, 32'h0);
    wr(ADDR_TGT_B_NS, 32'h320);
    wr(ADDR_TGT_B_SEC, 32'h0);
    wr(ADDR_INT_STAT, 32'h3);
    rchk("before match", ADDR_INT_STAT, 32'h0);
    repeat (30) @(posedge clock);
    rchk("match a", ADDR_INT_STAT, 32'h1);
    repeat (40) @(posedge clock);
    rchk("match b", ADDR_INT_STAT, 32'h3);
    $display("test timer_match done");
  endtask

  task automatic t_rate();
    wr(ADDR_TRIM, 32'hffffffff);
    rchk("trim mask", ADDR_TRIM, 32'hbfffffff);
    wr(ADDR_TRIM, 32'h0);
    clk_set(32'h5, 32'h3b9ac9f6, 32'h0);
    rchk("fold seconds", ADDR_CLK_SEC, 32'h6);
    rchk("fold ns", ADDR_CLK_NS, 32'h0);
    repeat (10) @(posedge clock);
    rchk("held ns", ADDR_CLK_NS, 32'h0);
    for (int d = 0; d < 2; d++) begin
      wr(ADDR_TRIM, {d[0], 31'h20000000});
      clk_set(32'h0, 32'h0, 32'he0000000);
      rchk("wrap ns", ADDR_CLK_NS, d ? 32'hb : 32'h9);
      rchk("wrap fraction", ADDR_CLK_FRAC, 32'h0);
    end
    wr(ADDR_TRIM, 32'h0);
    $display("test rate_trim done");
  endtask

  task automatic t_pin();
    wr(ADDR_INT_STAT, 32'h3);
    clk_set(32'h0, 32'h0, 32'h0);
    rchk("tick ns", ADDR_CLK_NS, 32'ha);
    repeat (100) @(posedge clock);
    rchk("rematch", ADDR_INT_STAT, 32'h3);
    wr(ADDR_GPIO_CLR, 32'h101);
    pin(1, 10);
    rchk("disabled pin", ADDR_INT_STAT, 32'h3);
    pin(0, 4);
    rchk("short pin", ADDR_INT_STAT, 32'h3);
    pin(0, 10);
    rchk("long pin", ADDR_INT_STAT, 32'h0);
    $display("test pin_clear done");
  endtask

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    busReq = '0;
    stampEvents = '0;
    gpioPin = 8'h0;
    failCount = 0;
    testsRun = 0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    t_reset();
    t_irq();
    t_match();
    t_rate();
    t_pin();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clock);
    $display("BAD watchdog expected done seen timeout");
    failCount++;
    end_sim();
  end

endmodule

`default_nettype wire
